/* File: core/smc_pkg.sv */
// package: register map, field layout and carriers for supply monitor control
package smc_pkg;

	// register addresses on the special function register port
	localparam logic [7:0] SMC_ADDR_KEY = 8'hC1;
	localparam logic [7:0] SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG = 8'hF4;
	localparam logic [7:0] SMC_ADDR_POLICY = 8'hF5;
	localparam logic [7:0] SMC_ADDR_FLAGS = 8'hF8;
	localparam logic [7:0] SMC_ADDR_INTPIN = 8'hFF;

	// unlock value for the interrupt-pin setup register
	localparam logic [7:0] SMC_UNLOCK_VALUE = 8'hEA;

	// event flag bit positions
	localparam int SMC_FLAG_RESTORED = 7;
	localparam int SMC_FLAG_SUMMARY = 6;
	localparam int SMC_FLAG_DIP = 5;
	localparam int SMC_FLAG_RSVD = 4;
	localparam int SMC_FLAG_INPUT_MON = 3;
	localparam int SMC_FLAG_BACKUP_MON = 2;
	localparam int SMC_FLAG_SWITCHOVER = 1;
	localparam int SMC_FLAG_INPUT_LOW = 0;

	// pin and supply config bit positions
	localparam int SMC_PC_RX_WAKE = 7;
	localparam int SMC_PC_SOURCE = 6;
	localparam int SMC_PC_SUPPLY_GOOD = 5;
	localparam int SMC_PC_LOCK_FAULT = 4;
	localparam int SMC_PC_REF_EN = 3;
	localparam int SMC_PC_RSVD = 2;
	localparam int SMC_PC_RXFN_LSB = 0;

	// reset values
	localparam logic [7:0] SMC_RST_KEY = 8'h00;
	localparam logic [7:0] SMC_RST_FLAGS = 8'h00;
	localparam logic [1:0] SMC_RST_POLICY = 2'h0;
	localparam logic [7:0] SMC_RST_INTPIN = 8'h00;
	localparam logic [1:0] SMC_RST_RXFN = 2'h0;
	localparam logic SMC_RST_SOURCE = 1'b1;
	localparam logic SMC_RST_SUPPLY_GOOD = 1'b1;

	// switchover policy codes
	localparam logic [1:0] SMC_POL_LOW_MAIN = 2'h0;
	localparam logic [1:0] SMC_POL_LOW_MAIN_INPUT = 2'h1;

	// receive pin function codes
	localparam logic [1:0] SMC_RX_GPIO = 2'h0;
	localparam logic [1:0] SMC_RX_SERIAL = 2'h1;
	localparam logic [1:0] SMC_RX_SERIAL_WAKE = 2'h3;

	// register port request from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smc_sfr_req_s;

	// analog and system event inputs, one-cycle pulses except levels noted
	typedef struct packed {
		logic main_low;
		logic input_low_lvl;
		logic main_good;
		logic dip;
		logic input_change;
		logic input_ready;
		logic backup_low;
		logic backup_ready;
		logic lock_lost;
		logic rx_edge;
		logic deep_sleep;
		logic lock_ack;
	} smc_events_s;

	// decoded control outputs
	typedef struct packed {
		logic on_backup;
		logic ref_enable;
		logic [1:0] rx_function;
		logic summary_irq;
		logic [7:0] intpin_cfg;
	} smc_ctrl_s;

	typedef enum logic {SMC_SRC_MAIN, SMC_SRC_BACKUP} smc_src_e;

endpackage : smc_pkg

/* File: core/smc_switch.sv */
// switched-supply source selector with change events
`timescale 1ns/1ps
module smc_switch
	import smc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// policy and supply conditions
	input wire logic [1:0] policy_i,
	input wire logic main_low_i,
	input wire logic input_low_i,
	// results
	output logic on_backup_o,
	output logic to_backup_o,
	output logic to_main_o
);
	import smc_pkg::*;

	typedef struct packed {
		smc_src_e src;
		logic to_backup;
		logic to_main;
	} smc_sw_state_s;

	smc_sw_state_s s_q, s_d;
	logic want_backup;

	always_comb
	begin
		s_d = s_q;
		s_d.to_backup = 1'b0;
		s_d.to_main = 1'b0;
		// policy picks the condition that moves the output to the backup cell
		case (policy_i)
			SMC_POL_LOW_MAIN: want_backup = main_low_i;
			SMC_POL_LOW_MAIN_INPUT: want_backup = main_low_i && input_low_i;
			default: want_backup = 1'b0;
		endcase
		case (s_q.src)
			SMC_SRC_MAIN:
			begin
				if (want_backup)
				begin
					s_d.src = SMC_SRC_BACKUP;
					s_d.to_backup = 1'b1;
				end
			end
			SMC_SRC_BACKUP:
			begin
				// return as soon as main is back, even if switchover got disabled
				if (!main_low_i)
				begin
					s_d.src = SMC_SRC_MAIN;
					s_d.to_main = 1'b1;
				end
			end
			default: s_d.src = SMC_SRC_MAIN;
		endcase
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			s_q <= '{src: SMC_SRC_MAIN, to_backup: 1'b0, to_main: 1'b0};
		else
			s_q <= s_d;
	end

	assign on_backup_o = (s_q.src == SMC_SRC_BACKUP);
	assign to_backup_o = s_q.to_backup;
	assign to_main_o = s_q.to_main;

endmodule : smc_switch

/* File: core/smc_top.sv */
// supply monitor control: key-protected setup, event flags, pin/supply config
`timescale 1ns/1ps
module smc_top
	import smc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// special function register port
	input wire smc_pkg::smc_sfr_req_s sfr_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// event enables held in the core's enable register
	input wire logic [7:0] event_enable_i,
	// analog and system events
	input wire smc_pkg::smc_events_s ev_i,
	// control outputs
	output smc_pkg::smc_ctrl_s ctrl_o
);
	import smc_pkg::*;

	typedef struct packed {
		logic [7:0] key;
		logic [7:0] flags;
		logic [1:0] policy;
		logic [7:0] intpin;
		logic rx_wake;
		logic lock_fault;
		logic ref_en;
		logic [1:0] rx_fn;
		logic [7:0] rdata;
		logic hit;
		logic summary_irq;
	} smc_state_s;

	smc_state_s s_q, s_d;
	logic on_backup, to_backup, to_main;
	logic [7:0] raw_events;
	logic [7:0] flag_wr_clear;
	logic summary_event;
	logic wr_flags, wr_pc, wr_policy, wr_key, wr_intpin;

	smc_switch u_switch (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.policy_i(s_q.policy),
		.main_low_i(ev_i.main_low),
		.input_low_i(ev_i.input_low_lvl),
		.on_backup_o(on_backup),
		.to_backup_o(to_backup),
		.to_main_o(to_main)
	);

	assign wr_key = sfr_i.wr && (sfr_i.addr == SMC_ADDR_KEY);
	assign wr_flags = sfr_i.wr && (sfr_i.addr == SMC_ADDR_FLAGS);
	assign wr_pc = sfr_i.wr && (sfr_i.addr == SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG);
	assign wr_policy = sfr_i.wr && (sfr_i.addr == SMC_ADDR_POLICY);
	assign wr_intpin = sfr_i.wr && (sfr_i.addr == SMC_ADDR_INTPIN);

	// per-flag event sources; bit 6 is derived, bit 4 has none
	always_comb
	begin
		raw_events = 8'h00;
		raw_events[SMC_FLAG_RESTORED] = to_main;
		raw_events[SMC_FLAG_DIP] = ev_i.dip;
		raw_events[SMC_FLAG_INPUT_MON] = ev_i.input_change
			|| ev_i.input_ready;
		raw_events[SMC_FLAG_BACKUP_MON] = ev_i.backup_low
			|| ev_i.backup_ready;
		raw_events[SMC_FLAG_SWITCHOVER] = to_backup;
		raw_events[SMC_FLAG_INPUT_LOW] = ev_i.input_low_lvl;
	end

	// only enabled conditions feed the summary; bit 6 enable is reserved
	assign summary_event = |(raw_events & event_enable_i
		& ~(8'h01 << SMC_FLAG_SUMMARY));

	assign flag_wr_clear = wr_flags ? ~sfr_i.wdata : 8'h00;

	always_comb
	begin
		s_d = s_q;
		if (wr_key)
			s_d.key = sfr_i.wdata;
		// key is not cleared by hardware: a left-open key leaves writes open
		if (wr_intpin && (s_q.key == SMC_UNLOCK_VALUE))
			s_d.intpin = sfr_i.wdata;
		// write-zero clears, set wins over clear in the same cycle
		s_d.flags = (s_q.flags & ~flag_wr_clear) | raw_events;
		if (summary_event)
			s_d.flags[SMC_FLAG_SUMMARY] = 1'b1;
		s_d.flags[SMC_FLAG_RSVD] = 1'b0;
		if (wr_policy)
			s_d.policy = sfr_i.wdata[1:0];
		if (wr_pc)
		begin
			s_d.ref_en = sfr_i.wdata[SMC_PC_REF_EN];
			s_d.rx_fn = sfr_i.wdata[SMC_PC_RXFN_LSB +: 2];
			if (!sfr_i.wdata[SMC_PC_RX_WAKE])
				s_d.rx_wake = 1'b0;
		end
		if (ev_i.rx_edge && ev_i.deep_sleep
			&& (s_q.rx_fn == SMC_RX_SERIAL_WAKE))
			s_d.rx_wake = 1'b1;
		if (ev_i.lock_ack)
			s_d.lock_fault = 1'b0;
		if (ev_i.lock_lost)
			s_d.lock_fault = 1'b1;
		s_d.hit = sfr_i.rd && (sfr_i.addr == SMC_ADDR_KEY
			|| sfr_i.addr == SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG
			|| sfr_i.addr == SMC_ADDR_POLICY
			|| sfr_i.addr == SMC_ADDR_FLAGS
			|| sfr_i.addr == SMC_ADDR_INTPIN);
		s_d.rdata = 8'h00;
		if (sfr_i.rd)
		begin
			case (sfr_i.addr)
				SMC_ADDR_KEY: s_d.rdata = s_q.key;
				SMC_ADDR_FLAGS: s_d.rdata = s_q.flags;
				SMC_ADDR_POLICY: s_d.rdata = {6'h00, s_q.policy};
				SMC_ADDR_INTPIN: s_d.rdata = s_q.intpin;
				SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG:
				begin
					s_d.rdata[SMC_PC_RX_WAKE] = s_q.rx_wake;
					s_d.rdata[SMC_PC_SOURCE] = ~on_backup;
					s_d.rdata[SMC_PC_SUPPLY_GOOD] = ev_i.main_good;
					s_d.rdata[SMC_PC_LOCK_FAULT] = s_q.lock_fault;
					s_d.rdata[SMC_PC_REF_EN] = s_q.ref_en;
					s_d.rdata[SMC_PC_RXFN_LSB +: 2] = s_q.rx_fn;
				end
				default: s_d.rdata = 8'h00;
			endcase
		end
		s_d.summary_irq = s_d.flags[SMC_FLAG_SUMMARY];
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_q.key <= SMC_RST_KEY;
			s_q.flags <= SMC_RST_FLAGS;
			s_q.policy <= SMC_RST_POLICY;
			s_q.intpin <= SMC_RST_INTPIN;
			s_q.rx_wake <= 1'b0;
			s_q.lock_fault <= 1'b0;
			s_q.ref_en <= 1'b0;
			s_q.rx_fn <= SMC_RST_RXFN;
			// read data idles at zero until the first read answers
			s_q.rdata <= 8'h00;
			s_q.hit <= 1'b0;
			s_q.summary_irq <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// outputs: everything except on_backup comes from this module's flops;
	// on_backup is the selector's own source flop
	assign sfr_rdata_o = s_q.rdata;
	assign sfr_hit_o = s_q.hit;
	assign ctrl_o = '{on_backup: on_backup, ref_enable: s_q.ref_en,
		rx_function: s_q.rx_fn, summary_irq: s_q.summary_irq,
		intpin_cfg: s_q.intpin};

	// assertions
	// named steps shared by the properties below
	sequence seq_locked_write;
		sfr_i.wr && sfr_i.addr == SMC_ADDR_INTPIN
			&& s_q.key != SMC_UNLOCK_VALUE;
	endsequence

	sequence seq_unlocked_write;
		sfr_i.wr && sfr_i.addr == SMC_ADDR_INTPIN
			&& s_q.key == SMC_UNLOCK_VALUE;
	endsequence

	sequence seq_pc_read;
		sfr_i.rd && sfr_i.addr == SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG;
	endsequence

	sequence seq_flags_read;
		sfr_i.rd && sfr_i.addr == SMC_ADDR_FLAGS;
	endsequence

	// a move of the output shows at once, its flag one cycle later
	sequence seq_moved_backup;
		on_backup && to_backup ##1 s_q.flags[SMC_FLAG_SWITCHOVER];
	endsequence

	sequence seq_moved_main;
		!on_backup && to_main ##1 s_q.flags[SMC_FLAG_RESTORED];
	endsequence

	// protected setup register and its key
	a_intpin_locked: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		seq_locked_write |=> $stable(s_q.intpin))
		else $error("locked setup register changed");
	a_intpin_unlocked: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		seq_unlocked_write |=> s_q.intpin == $past(sfr_i.wdata))
		else $error("unlocked write not stored");
	a_key_store: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		wr_key |=> s_q.key == $past(sfr_i.wdata))
		else $error("key write not stored");
	// hardware never relocks, so only software may move the key
	a_key_kept: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		!wr_key |=> $stable(s_q.key))
		else $error("key changed without a write");

	// event flags
	a_restore_flag: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		to_main |=> s_q.flags[SMC_FLAG_RESTORED])
		else $error("restored flag missed");
	a_summary_set: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		summary_event |=> s_q.flags[SMC_FLAG_SUMMARY]
		##1 ctrl_o.summary_irq)
		else $error("summary flag missed");
	a_summary_masked: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(!summary_event && !s_q.flags[SMC_FLAG_SUMMARY])
		|=> !s_q.flags[SMC_FLAG_SUMMARY])
		else $error("summary flag set without an enabled event");
	a_dip_flag: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		ev_i.dip |=> s_q.flags[SMC_FLAG_DIP])
		else $error("dip flag missed");
	a_input_mon: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(ev_i.input_change || ev_i.input_ready)
		|=> s_q.flags[SMC_FLAG_INPUT_MON])
		else $error("input monitor flag missed");
	a_backup_mon: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(ev_i.backup_low || ev_i.backup_ready)
		|=> s_q.flags[SMC_FLAG_BACKUP_MON])
		else $error("backup monitor flag missed");
	a_input_low: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		ev_i.input_low_lvl |=> s_q.flags[SMC_FLAG_INPUT_LOW])
		else $error("input low flag missed");
	a_flags_read: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		seq_flags_read |=> sfr_hit_o && sfr_rdata_o == $past(s_q.flags))
		else $error("flag read does not match the flags");
	a_set_wins: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(wr_flags && sfr_i.wdata == 8'h00 && ev_i.dip)
		|=> s_q.flags[SMC_FLAG_DIP])
		else $error("event lost against clear");
	a_flag_sticky: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(s_q.flags[SMC_FLAG_DIP] && !wr_flags)
		|=> s_q.flags[SMC_FLAG_DIP])
		else $error("flag dropped without clear");
	a_flag_clear: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(wr_flags && !sfr_i.wdata[SMC_FLAG_DIP] && !ev_i.dip)
		|=> !s_q.flags[SMC_FLAG_DIP])
		else $error("written zero did not clear the flag");

	// switchover policy and supply source
	a_switch_enter: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(!on_backup && ev_i.main_low && (s_q.policy == SMC_POL_LOW_MAIN
		|| (s_q.policy == SMC_POL_LOW_MAIN_INPUT && ev_i.input_low_lvl)))
		|=> seq_moved_backup)
		else $error("switchover not taken");
	a_switch_flag: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		to_backup |-> on_backup ##1 s_q.flags[SMC_FLAG_SWITCHOVER])
		else $error("switchover flag missed");
	a_policy_off: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(!on_backup && (s_q.policy[1] || !ev_i.main_low
		|| (s_q.policy == SMC_POL_LOW_MAIN_INPUT && !ev_i.input_low_lvl)))
		|=> !on_backup && !to_backup)
		else $error("switchover against the policy");
	a_return_main: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(on_backup && !ev_i.main_low) |=> seq_moved_main)
		else $error("return to main supply missed");
	a_source_read: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		seq_pc_read |=> sfr_rdata_o[SMC_PC_SOURCE] == $past(!on_backup))
		else $error("supply source bit wrong");
	a_good_read: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		seq_pc_read |=> sfr_rdata_o[SMC_PC_SUPPLY_GOOD]
		== $past(ev_i.main_good))
		else $error("supply good bit wrong");

	// pin and supply configuration
	a_ref_write: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		wr_pc |=> ctrl_o.ref_enable == $past(sfr_i.wdata[SMC_PC_REF_EN]))
		else $error("reference enable not stored");
	a_rxfn_write: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		wr_pc |=> ctrl_o.rx_function
		== $past(sfr_i.wdata[SMC_PC_RXFN_LSB +: 2]))
		else $error("receive pin function not stored");
	a_rx_wake: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(ev_i.rx_edge && ev_i.deep_sleep && s_q.rx_fn == SMC_RX_SERIAL_WAKE)
		|=> s_q.rx_wake)
		else $error("receive wake flag missed");
	a_wake_quiet: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(!s_q.rx_wake && !(ev_i.rx_edge && ev_i.deep_sleep
		&& s_q.rx_fn == SMC_RX_SERIAL_WAKE)) |=> !s_q.rx_wake)
		else $error("receive wake flag set without a wake edge");
	a_fault_set: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		ev_i.lock_lost |=> s_q.lock_fault)
		else $error("lock fault missed");
	a_fault_hold: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(s_q.lock_fault && !ev_i.lock_ack) |=> s_q.lock_fault)
		else $error("lock fault cleared without acknowledge");
	a_fault_clear: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		(ev_i.lock_ack && !ev_i.lock_lost) |=> !s_q.lock_fault)
		else $error("acknowledge did not clear lock fault");
	a_read_idle: assert property (@(posedge mclk_i)
		disable iff (reset_i)
		!sfr_i.rd |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
		else $error("read answer without a read");

endmodule : smc_top

/* File: sim/smc_core_model.sv */
// core-side model that issues special function register requests
`timescale 1ns/1ps
module smc_core_model
	import smc_pkg::*;
(
	// clock
	input wire logic mclk_i,
	// request to the block
	output smc_pkg::smc_sfr_req_s req_o
);
	import smc_pkg::*;
	initial
	begin
		req_o = '0;
	end
	// one request per call; reserved bits are forced to zero like real code
	task automatic send(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = d;
		if (a == SMC_ADDR_FLAGS) m[SMC_FLAG_RSVD] = 1'b0;
		if (a == SMC_ADDR_POLICY) m[7:2] = 6'h00;
		if (a == SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG) m[SMC_PC_RSVD] = 1'b0;
		@(negedge mclk_i);
		req_o.wr = w;
		req_o.rd = ~w;
		req_o.addr = a;
		req_o.wdata = m;
	endtask : send
	// released lines show the inverse so stale values cannot pass
	task automatic idle();
		@(negedge mclk_i);
		req_o.wr = 1'b0;
		req_o.rd = 1'b0;
		req_o.addr = ~req_o.addr;
		req_o.wdata = ~req_o.wdata;
	endtask : idle
	// unlock, write, relock back to back
	task automatic prot(input logic [7:0] d);
		send(1'b1, SMC_ADDR_KEY, SMC_UNLOCK_VALUE);
		send(1'b1, SMC_ADDR_INTPIN, d);
		send(1'b1, SMC_ADDR_KEY, 8'h00);
		idle();
	endtask : prot
endmodule : smc_core_model

/* File: sim/smc_top_tb.sv */
// self-checking testbench for supply monitor control
`timescale 1ns/1ps
module smc_top_tb;
	import smc_pkg::*;
	logic mclk_i;
	logic reset_i;
	smc_sfr_req_s req;
	logic [7:0] rdata;
	logic hit;
	logic [7:0] en;
	smc_events_s ev;
	smc_ctrl_s ctrl;
	int err_total;
	int total_checks;
	logic [8:0] exp_q[$];
	logic took;
	int i;
	logic [7:0] d;
	logic [7:0] e;
	logic sw;
	logic inl;
	logic rf;
	logic [1:0] pol;
	logic [1:0] fn;
	int evb[6] = '{10, 8, 7, 6, 5, 4};
	int fb[6] = '{0, 5, 3, 3, 2, 2};
	smc_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .sfr_i(req),
		.sfr_rdata_o(rdata), .sfr_hit_o(hit), .event_enable_i(en),
		.ev_i(ev), .ctrl_o(ctrl));
	smc_core_model core (.mclk_i(mclk_i), .req_o(req));
	initial
	begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [8:0] x, input logic [8:0] g);
		total_checks++;
		if (g !== x)
		begin
			$display("FAIL %s expected %h seen %h", nm, x, g);
			err_total++;
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [8:0] x);
		exp_q.push_back(x);
		core.send(1'b0, a, 8'h00);
		core.idle();
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		core.send(1'b1, a, v);
		core.idle();
	endtask : wr
	task automatic pulse(input logic [11:0] p);
		@(negedge mclk_i);
		ev = ev | p;
		@(negedge mclk_i);
		ev = ev & ~p;
	endtask : pulse
	// read answer stands from the taking edge and is checked half a cycle later
	always @(posedge mclk_i) took <= req.rd;
	always @(negedge mclk_i)
	begin
		if (took === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("read order", 9'h1FF, {hit, rdata});
			else
				chk("read data", exp_q.pop_front(), {hit, rdata});
		end
	end
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		results();
	end
	initial
	begin
		reset_i = 1'b1;
		en = 8'h00;
		ev = '0;
		ev.main_good = 1'b1;
		took = 1'b0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(48));
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i) reset_i = 1'b0;
		rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 9'h160);
		rd(SMC_ADDR_FLAGS, 9'h100);
		rd(SMC_ADDR_POLICY, 9'h100);
		rd(SMC_ADDR_INTPIN, 9'h100);
		rd(SMC_ADDR_KEY, 9'h100);
		rd(8'h10, 9'h000);
		d = 8'($urandom()) | 8'h01;
		wr(SMC_ADDR_INTPIN, d);
		rd(SMC_ADDR_INTPIN, 9'h100);
		wr(SMC_ADDR_KEY, 8'hEB);
		wr(SMC_ADDR_INTPIN, d);
		rd(SMC_ADDR_INTPIN, 9'h100);
		core.prot(d);
		rd(SMC_ADDR_INTPIN, {1'b1, d});
		chk("intpin_cfg", {1'b0, d}, {1'b0, ctrl.intpin_cfg});
		rd(SMC_ADDR_KEY, 9'h100);
		wr(SMC_ADDR_INTPIN, ~d);
		rd(SMC_ADDR_INTPIN, {1'b1, d});
		for (i = 0; i < 6; i++)
		begin
			en = 8'($urandom());
			pulse(12'h001 << evb[i]);
			e = 8'h00;
			e[fb[i]] = 1'b1;
			e[6] = en[fb[i]];
			rd(SMC_ADDR_FLAGS, {1'b1, e});
			chk("summary_irq", {8'h00, e[6]}, {8'h00, ctrl.summary_irq});
			wr(SMC_ADDR_FLAGS, 8'h00);
			rd(SMC_ADDR_FLAGS, 9'h100);
		end
		en = 8'h00;
		pulse(12'h100);
		wr(SMC_ADDR_FLAGS, 8'hFF);
		rd(SMC_ADDR_FLAGS, 9'h120);
		fork
			begin
				core.send(1'b1, SMC_ADDR_FLAGS, 8'h00);
				core.idle();
			end
			pulse(12'h100);
		join
		rd(SMC_ADDR_FLAGS, 9'h120);
		wr(SMC_ADDR_FLAGS, 8'h00);
		for (i = 0; i < 5; i++)
		begin
			pol = (i == 4) ? 2'h1 : 2'(i);
			inl = (i == 4);
			sw = (pol == 2'h0) || (pol == 2'h1 && inl);
			wr(SMC_ADDR_POLICY, {6'h3F, pol});
			rd(SMC_ADDR_POLICY, {1'b1, 6'h00, pol});
			@(negedge mclk_i);
			ev.main_low = 1'b1;
			ev.input_low_lvl = inl;
			repeat (3) @(negedge mclk_i);
			chk("on_backup", {8'h00, sw}, {8'h00, ctrl.on_backup});
			rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, {2'b10, ~sw, 6'h20});
			rd(SMC_ADDR_FLAGS, {1'b1, 6'h00, sw, inl});
			ev.main_low = 1'b0;
			ev.input_low_lvl = 1'b0;
			repeat (3) @(negedge mclk_i);
			rd(SMC_ADDR_FLAGS, {1'b1, sw, 5'h00, sw, inl});
			wr(SMC_ADDR_FLAGS, 8'h00);
		end
		for (i = 0; i < 3; i++)
		begin
			fn = (i == 2) ? 2'h3 : 2'(i);
			rf = (i == 1);
			ev.main_good = (i != 1);
			ev.deep_sleep = 1'b1;
			wr(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, {4'hF, rf, 1'b1, fn});
			pulse(12'h004);
			rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, {1'b1, fn == 2'h3, 1'b1, i != 1, 1'b0,
				rf, 1'b0, fn});
			chk("rx_function", {7'h00, fn}, {7'h00, ctrl.rx_function});
			chk("ref_enable", {8'h00, rf}, {8'h00, ctrl.ref_enable});
		end
		ev.deep_sleep = 1'b0;
		ev.main_good = 1'b1;
		wr(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 8'h00);
		rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 9'h160);
		pulse(12'h008);
		wr(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 8'h00);
		rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 9'h170);
		pulse(12'h009);
		rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 9'h170);
		pulse(12'h001);
		rd(SMC_ADDR_PIN_AND_SUPPLY_CONFIG_CFG, 9'h160);
		@(negedge mclk_i) reset_i = 1'b1;
		@(negedge mclk_i) reset_i = 1'b0;
		rd(SMC_ADDR_INTPIN, 9'h100);
		rd(SMC_ADDR_POLICY, 9'h100);
		for (i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge mclk_i);
		if (exp_q.size() != 0) err_total++;
		results();
	end
endmodule : smc_top_tb
